// ===== core/asr_pkg.sv
// Constants and types shared by the asynchronous serial receiver
//
// Function
// - Data recovery samples at 16x baud; shift register advances once per bit.
// - Reception starts only after software sets continuous receive enable, status bit 4.
// - After the stop bit the assembled word moves into the FIFO if room.
// - A word entering the FIFO sets the receive data flag, flags bit 5.
// - Receive interrupt requested only while enable bit 5 set; flag sets regardless.
// - Receive data flag is read-only; clears once data read and FIFO empty.
// - FIFO holds two words; a third may shift in; reads return in order.
// - Stop bit with FIFO full sets overrun error, status bit 1; word discarded.
// - Overrun error clears only by clearing then setting continuous receive enable.
// - While overrun error is set, no word moves into the FIFO.
// - A low sampled stop bit sets the framing error, status bit 2.
// - Framing error and ninth bit travel with each word; reads advance them.
// - Nine-bit select, set before enabling, captures a ninth data bit per frame.
// - Frame: one start bit, eight or nine data bits LSB first, one stop.
// - Baud generator runs at 16x or 64x bit rate, chosen by high baud select.
`default_nettype none
package asr_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_RX_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_TX_BUF     = 8'h19;
  localparam logic [7:0] ADDR_RX_DATA    = 8'h1A;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h1B;
  localparam logic [7:0] ADDR_EVT_MASK   = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h8C;
  localparam logic [7:0] ADDR_TX_STATUS  = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIV   = 8'h99;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int unsigned RX_FLAG_BIT = 5;
  localparam int unsigned RX_IE_BIT   = 5;
  localparam int unsigned SERIAL_PORT_ENABLE_BIT    = 7;
  localparam int unsigned NINE_BIT    = 6;
  localparam int unsigned CONTINUOUS_RECEIVE_ENABLE_BIT    = 4;
  localparam int unsigned FRAMING_ERROR_BIT    = 2;
  localparam int unsigned OVERRUN_ERROR_BIT    = 1;
  localparam int unsigned RECEIVED_NINTH_BIT_BIT    = 0;
  localparam int unsigned SYNC_BIT    = 4;
  localparam int unsigned HIGH_BAUD_SELECT_BIT    = 2;
  localparam int unsigned TRMT_BIT    = 1;
  localparam int unsigned EVT_WORD    = 0;
  localparam int unsigned EVT_OVERRUN = 1;
  localparam int unsigned EVT_FRAMING = 2;
  localparam int unsigned EVT_W       = 3;

  // ****************************************************
  // Reset values and write masks
  // ****************************************************
  localparam logic [7:0] RX_STATUS_RST     = 8'h00;
  localparam logic [7:0] TX_STATUS_RST     = 8'h02;
  localparam logic [7:0] REG_RST           = 8'h00;
  localparam logic [7:0] RX_STATUS_WR_MASK = 8'hF0;
  localparam logic [7:0] TX_STATUS_WR_MASK = 8'hF5;

  // ****************************************************
  // Frame and oversampling
  // ****************************************************
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ENTRY_W    = 10;
  localparam int unsigned NINTH_POS  = 8;
  localparam int unsigned FRAMING_ERROR_POS   = 9;
  localparam logic [3:0]  TICK_LAST  = 4'hF;
  localparam logic [3:0]  MID_TICK   = 4'h7;
  localparam logic [3:0]  LAST_IDX8  = 4'h7;
  localparam logic [3:0]  LAST_IDX9  = 4'h8;
  localparam logic [1:0]  PRE_LOW_LAST = 2'h3;

  // Gray-coded receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } asr_rx_state_e;

endpackage : asr_pkg
`default_nettype wire

// ===== core/asr_baud_gen.sv
// Baud-rate generator producing the 16x oversampling tick
`timescale 1ns/1ps
`default_nettype none
module asr_baud_gen #(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_divisor,
  input  wire logic             i_high_baud,
  output logic                  o_tick
);
  import asr_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic [1:0]       pre_cnt;
    logic             tick;
  } asr_bg_s;

  asr_bg_s r;
  asr_bg_s nxt;

  if (DIV_W < 1) begin : g_chk
    $error("asr_baud_gen: DIV_W must be at least 1");
  end

  // Divide by divisor+1, then by 4 unless high baud is chosen
  always_comb begin
    nxt      = r;
    nxt.tick = 1'b0;
    if (!i_run) begin
      nxt.div_cnt = i_divisor;
      nxt.pre_cnt = 2'h0;
    end else if (r.div_cnt == '0) begin
      nxt.div_cnt = i_divisor;
      if (i_high_baud || r.pre_cnt == PRE_LOW_LAST) begin
        nxt.tick    = 1'b1;
        nxt.pre_cnt = 2'h0;
      end else begin
        nxt.pre_cnt = r.pre_cnt + 2'h1;
      end
    end else begin
      nxt.div_cnt = r.div_cnt - DIV_W'(1);
    end
  end

  // Reloaded with the divisor while stopped so the first tick is a full period away
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign o_tick = r.tick;

endmodule : asr_baud_gen
`default_nettype wire

// ===== core/asr_receiver.sv
// Asynchronous serial receiver with register port and two-deep receive FIFO
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module asr_receiver #(
  parameter int unsigned FIFO_DEPTH = 2
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_strobe,
  input  wire logic       i_rd_strobe,
  input  wire logic       i_rx_pin,
  output logic      [7:0] o_rd_data,
  output logic            o_irq,
  output logic            o_rx_irq
);
  import asr_pkg::*;

  localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("asr_receiver: FIFO_DEPTH must be a power of two, at least 2");
  end

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    asr_rx_state_e                       state;
    logic [3:0]                          tick_cnt;
    logic [3:0]                          bit_idx;
    logic [8:0]                          shift;
    logic                                line_prev;
    logic [FIFO_DEPTH-1:0][ENTRY_W-1:0]  fifo;
    logic [PTR_W-1:0]                    rd_ptr;
    logic [PTR_W-1:0]                    wr_ptr;
    logic [CNT_W-1:0]                    count;
    logic                                overrun_error;
    logic [7:0]                          rx_ctl;
    logic [7:0]                          tx_ctl;
    logic [7:0]                          tx_buf;
    logic [7:0]                          baud_div;
    logic [7:0]                          irq_en;
    logic [EVT_W-1:0]                    evt_status;
    logic [EVT_W-1:0]                    evt_mask;
    logic [7:0]                          rd_data;
    logic                                irq;
    logic                                rx_irq;
  } asr_rx_s;

  localparam asr_rx_s ST_RST = '{
    state:     RX_IDLE,
    line_prev: 1'b1,
    rx_ctl:    RX_STATUS_RST,
    tx_ctl:    TX_STATUS_RST,
    tx_buf:    REG_RST,
    baud_div:  REG_RST,
    irq_en:    REG_RST,
    default:   '0
  };

  asr_rx_s              r;
  asr_rx_s              nxt;
  logic                 baud_tick;
  logic                 rx_en;
  logic                 brg_run;
  logic                 full;
  logic                 rx_flag;
  logic                 push;
  logic                 pop;
  logic                 frame_done;
  logic [ENTRY_W-1:0]   head;
  logic [ENTRY_W-1:0]   entry;
  logic [EVT_W-1:0]     evt_set;
  logic [EVT_W-1:0]     evt_clr;
  logic [7:0]           rd_val;
  logic [3:0]           last_idx;

  // Place one bit at a field position of an 8-bit register image
  function automatic logic [7:0] bit_at(input int unsigned pos, input logic v);
    logic [7:0] img;
    img      = 8'h00;
    img[pos] = v;
    return img;
  endfunction : bit_at

  // ****************************************************
  // Baud-rate generator
  // ****************************************************
  // Stopped while the receiver is off, so a fresh enable starts clean
  assign brg_run = rx_en;

  asr_baud_gen #(
    .DIV_W (8)
  ) u_baud (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_run       (brg_run),
    .i_divisor   (r.baud_div),
    .i_high_baud (r.tx_ctl[HIGH_BAUD_SELECT_BIT]),
    .o_tick      (baud_tick)
  );

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    nxt        = r;
    push       = 1'b0;
    pop        = 1'b0;
    frame_done = 1'b0;
    evt_set    = '0;
    evt_clr    = '0;
    rd_val     = 8'h00;
    // Asynchronous mode needs port enabled, sync cleared, receive enabled
    rx_en      = r.rx_ctl[SERIAL_PORT_ENABLE_BIT] & r.rx_ctl[CONTINUOUS_RECEIVE_ENABLE_BIT] & ~r.tx_ctl[SYNC_BIT];
    full       = (r.count == FULL_CNT);
    rx_flag    = (r.count != '0);
    head       = r.fifo[r.rd_ptr];
    last_idx   = r.rx_ctl[NINE_BIT] ? LAST_IDX9 : LAST_IDX8;
    entry      = {~i_rx_pin, r.shift};

    // Clearing receive enable resets the receive logic and the overrun error
    if (!r.rx_ctl[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
      nxt.overrun_error = 1'b0;
    end

    // Receive sequencer, advanced only on the 16x tick
    if (!rx_en) begin
      nxt.state     = RX_IDLE;
      nxt.tick_cnt  = 4'h0;
      nxt.line_prev = i_rx_pin;
    end else if (baud_tick) begin
      nxt.line_prev = i_rx_pin;
      case (r.state)
        RX_IDLE: begin
          // Falling edge of the idle-high line marks a start bit
          if (r.line_prev && !i_rx_pin) begin
            nxt.state    = RX_START;
            nxt.tick_cnt = 4'h0;
          end
        end
        RX_START: begin
          if (r.tick_cnt == MID_TICK) begin
            nxt.tick_cnt = 4'h0;
            nxt.bit_idx  = 4'h0;
            nxt.shift    = 9'h000;
            // A glitch that is high again by mid-bit is not a start
            nxt.state    = i_rx_pin ? RX_IDLE : RX_DATA;
          end else begin
            nxt.tick_cnt = r.tick_cnt + 4'h1;
          end
        end
        RX_DATA: begin
          // Sixteen ticks per bit; the shifter moves once per bit period
          if (r.tick_cnt == TICK_LAST) begin
            nxt.tick_cnt              = 4'h0;
            nxt.shift[r.bit_idx[3:0]] = i_rx_pin;
            if (r.bit_idx == last_idx) begin
              nxt.state = RX_STOP;
            end else begin
              nxt.bit_idx = r.bit_idx + 4'h1;
            end
          end else begin
            nxt.tick_cnt = r.tick_cnt + 4'h1;
          end
        end
        RX_STOP: begin
          if (r.tick_cnt == TICK_LAST) begin
            frame_done   = 1'b1;
            nxt.tick_cnt = 4'h0;
            nxt.state    = RX_IDLE;
          end else begin
            nxt.tick_cnt = r.tick_cnt + 4'h1;
          end
        end
        default: begin
          nxt.state = RX_IDLE;
        end
      endcase
    end

    // Stop bit sampled: hand the word over, or flag the overrun
    if (frame_done) begin
      if (!i_rx_pin) begin
        evt_set[EVT_FRAMING] = 1'b1;
      end
      if (r.overrun_error) begin
        push = 1'b0;
      end else if (full) begin
        nxt.overrun_error             = 1'b1;
        evt_set[EVT_OVERRUN] = 1'b1;
      end else begin
        push              = 1'b1;
        evt_set[EVT_WORD] = 1'b1;
      end
    end

    // Register writes
    if (i_wr_strobe) begin
      if (i_addr == ADDR_RX_STATUS) begin
        nxt.rx_ctl = i_wr_data & RX_STATUS_WR_MASK;
      end else if (i_addr == ADDR_TX_BUF) begin
        nxt.tx_buf = i_wr_data;
      end else if (i_addr == ADDR_IRQ_EN) begin
        nxt.irq_en = i_wr_data;
      end else if (i_addr == ADDR_TX_STATUS) begin
        nxt.tx_ctl = (i_wr_data & TX_STATUS_WR_MASK) | TX_STATUS_RST;
      end else if (i_addr == ADDR_BAUD_DIV) begin
        nxt.baud_div = i_wr_data;
      end else if (i_addr == ADDR_EVT_STATUS) begin
        evt_clr = i_wr_data[EVT_W-1:0];
      end else if (i_addr == ADDR_EVT_MASK) begin
        nxt.evt_mask = i_wr_data[EVT_W-1:0];
      end
    end

    // Register reads; status shows the head entry's flags until popped
    if (i_rd_strobe) begin
      if (i_addr == ADDR_IRQ_FLAGS) begin
        rd_val = bit_at(RX_FLAG_BIT, rx_flag);
      end else if (i_addr == ADDR_RX_STATUS) begin
        rd_val = r.rx_ctl | bit_at(OVERRUN_ERROR_BIT, r.overrun_error)
               | bit_at(FRAMING_ERROR_BIT, rx_flag & head[FRAMING_ERROR_POS])
               | bit_at(RECEIVED_NINTH_BIT_BIT, rx_flag & head[NINTH_POS]);
      end else if (i_addr == ADDR_TX_BUF) begin
        rd_val = r.tx_buf;
      end else if (i_addr == ADDR_RX_DATA) begin
        rd_val = rx_flag ? head[DATA_W-1:0] : 8'h00;
        pop    = rx_flag;
      end else if (i_addr == ADDR_EVT_STATUS) begin
        rd_val = {{(8 - EVT_W){1'b0}}, r.evt_status};
      end else if (i_addr == ADDR_EVT_MASK) begin
        rd_val = {{(8 - EVT_W){1'b0}}, r.evt_mask};
      end else if (i_addr == ADDR_IRQ_EN) begin
        rd_val = r.irq_en;
      end else if (i_addr == ADDR_TX_STATUS) begin
        rd_val = r.tx_ctl;
      end else if (i_addr == ADDR_BAUD_DIV) begin
        rd_val = r.baud_div;
      end else begin
        rd_val = 8'h00;
      end
    end
    nxt.rd_data = rd_val;

    // FIFO pointers; push and pop may meet in one cycle
    if (push) begin
      nxt.fifo[r.wr_ptr] = entry;
      nxt.wr_ptr         = r.wr_ptr + PTR_W'(1);
    end
    if (pop) begin
      nxt.rd_ptr = r.rd_ptr + PTR_W'(1);
    end
    if (push && !pop) begin
      nxt.count = r.count + CNT_W'(1);
    end else if (pop && !push) begin
      nxt.count = r.count - CNT_W'(1);
    end

    // Sticky events: a new event beats a write-one clear
    nxt.evt_status = (r.evt_status & ~evt_clr) | evt_set;
    nxt.irq        = |(nxt.evt_status & nxt.evt_mask);
    // Receive interrupt line gated by its enable; the flag is not
    nxt.rx_irq     = (nxt.count != '0) & nxt.irq_en[RX_IE_BIT];
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      r <= ST_RST;
    end else begin
      r <= nxt;
    end
  end

  assign o_rd_data = r.rd_data;
  assign o_irq     = r.irq;
  assign o_rx_irq  = r.rx_irq;

  // ****************************************************
  // Assertions
  // ****************************************************
  logic st_idle;
  logic overrun_error_q;
  logic continuous_receive_enable_q;
  assign st_idle = (r.state == RX_IDLE);
  assign overrun_error_q  = r.overrun_error;
  assign continuous_receive_enable_q  = r.rx_ctl[CONTINUOUS_RECEIVE_ENABLE_BIT];

  sequence s_stop_full;
    r.state == RX_STOP && baud_tick && r.tick_cnt == TICK_LAST && rx_en && full && !r.overrun_error;
  endsequence

  sequence s_data_read;
    i_rd_strobe && i_addr == ADDR_RX_DATA && rx_flag;
  endsequence

  property p_start_gated;
    @(posedge i_clock) disable iff (i_reset) st_idle && !rx_en |=> st_idle;
  endproperty
  a_start_gated: assert property (p_start_gated)
    else $error("receiver left idle while reception disabled");

  property p_flag_on_push;
    @(posedge i_clock) disable iff (i_reset) push |=> rx_flag ##0 r.count != '0;
  endproperty
  a_flag_on_push: assert property (p_flag_on_push)
    else $error("receive flag not set after word stored");

  property p_irq_gate;
    @(posedge i_clock) disable iff (i_reset)
      o_rx_irq |-> rx_flag && r.irq_en[RX_IE_BIT];
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("receive interrupt without flag and enable");

  property p_flag_clear;
    @(posedge i_clock) disable iff (i_reset) $fell(rx_flag) |-> $past(pop);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("receive flag cleared without a data read");

  property p_depth;
    @(posedge i_clock) disable iff (i_reset) r.count <= FULL_CNT;
  endproperty
  a_depth: assert property (p_depth)
    else $error("receive FIFO count beyond depth");

  property p_overrun_set;
    @(posedge i_clock) disable iff (i_reset) s_stop_full |=> r.overrun_error && $stable(r.count);
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun not flagged or word stored into full FIFO");

  property p_overrun_error_hold;
    @(posedge i_clock) disable iff (i_reset) $fell(overrun_error_q) |-> $past(!continuous_receive_enable_q);
  endproperty
  a_overrun_error_hold: assert property (p_overrun_error_hold)
    else $error("overrun error cleared while reception enabled");

  property p_no_push_overrun_error;
    @(posedge i_clock) disable iff (i_reset) r.overrun_error |-> !push;
  endproperty
  a_no_push_overrun_error: assert property (p_no_push_overrun_error)
    else $error("word stored while overrun error set");

  // The cycle after a data read must show the entry that was at the head
  property p_read_order;
    @(posedge i_clock) disable iff (i_reset)
      s_data_read |=> o_rd_data == $past(head[DATA_W-1:0]);
  endproperty
  a_read_order: assert property (p_read_order)
    else $error("data read did not return the oldest word");

endmodule : asr_receiver
`default_nettype wire

// ===== testbench/asr_tx_model.sv
// Behavioural model of the remote asynchronous serial transmitter
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model (
  input  wire logic i_clock,
  output logic      o_line
);
  // ****************************************************
  // Line driver
  // ****************************************************
  logic line_r = 1'b1;  // Idle level is high, as a released line with a pull-up
  assign o_line = line_r;

  // One frame: start low, data LSB first, optional ninth bit, stop level as given
  // Bit length is in clocks so the same model covers the 16x and 64x rates
  task automatic send(input logic [8:0] d, input logic nine, input logic stp, input int clks);
    logic [10:0] f;
    int          n;
    n = nine ? 11 : 10;
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < n; i++) begin
      @(posedge i_clock);
      line_r <= f[i];
      repeat (clks - 1) @(posedge i_clock);
    end
    // Return to idle even after a bad stop bit
    @(posedge i_clock);
    line_r <= 1'b1;
  endtask : send
endmodule : asr_tx_model
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking testbench of the asynchronous serial receiver
`timescale 1ns/1ps
`default_nettype none
module tb;
  import asr_pkg::*;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic       wr;
    logic [7:0] e;
  } asr_row_s;

  localparam int LIMIT = 30000;  // Whole run needs roughly 3500 cycles

  // ****************************************************
  // Signals and instances
  // ****************************************************
  logic       i_clock     = 1'b0;
  logic       i_reset     = 1'b1;
  logic       i_wr_strobe = 1'b0;
  logic       i_rd_strobe = 1'b0;
  logic [7:0] i_addr      = 8'h00;
  logic [7:0] i_wr_data   = 8'h00;
  wire        rx_line;
  logic [7:0] o_rd_data;
  logic       o_irq;
  logic       o_rx_irq;
  int         num_errors  = 0;
  int         n_tests     = 0;
  int         cyc         = 0;

  // Reset values first, then write and read back with the access masks applied
  asr_row_s rows [19] = '{
    '{ADDR_IRQ_FLAGS, 8'h00, 1'b0, 8'h00}, '{ADDR_RX_STATUS, 8'h00, 1'b0, 8'h00},
    '{ADDR_TX_BUF, 8'h00, 1'b0, 8'h00}, '{ADDR_RX_DATA, 8'h00, 1'b0, 8'h00},
    '{ADDR_IRQ_EN, 8'h00, 1'b0, 8'h00}, '{ADDR_TX_STATUS, 8'h00, 1'b0, 8'h02},
    '{ADDR_BAUD_DIV, 8'h00, 1'b0, 8'h00}, '{ADDR_EVT_STATUS, 8'h00, 1'b0, 8'h00},
    '{ADDR_EVT_MASK, 8'h00, 1'b0, 8'h00}, '{8'h55, 8'h00, 1'b0, 8'h00},
    '{ADDR_TX_BUF, 8'hA5, 1'b1, 8'hA5}, '{ADDR_BAUD_DIV, 8'h3C, 1'b1, 8'h3C},
    '{ADDR_TX_STATUS, 8'hFF, 1'b1, 8'hF7}, '{ADDR_IRQ_EN, 8'h20, 1'b1, 8'h20},
    '{ADDR_EVT_MASK, 8'hFF, 1'b1, 8'h07}, '{ADDR_IRQ_FLAGS, 8'hFF, 1'b1, 8'h00},
    '{ADDR_RX_DATA, 8'hFF, 1'b1, 8'h00}, '{8'h55, 8'hFF, 1'b1, 8'h00},
    '{ADDR_RX_STATUS, 8'hE0, 1'b1, 8'hE0}
  };

  asr_receiver DUT (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_addr      (i_addr),
    .i_wr_data   (i_wr_data),
    .i_wr_strobe (i_wr_strobe),
    .i_rd_strobe (i_rd_strobe),
    .i_rx_pin    (rx_line),
    .o_rd_data   (o_rd_data),
    .o_irq       (o_irq),
    .o_rx_irq    (o_rx_irq)
  );

  asr_tx_model u_tx (
    .i_clock (i_clock),
    .o_line  (rx_line)
  );

  // ****************************************************
  // Clock, timeout and tasks
  // ****************************************************
  initial begin
    forever #2 i_clock = ~i_clock;
  end

  // A hang counts as a mismatch and still ends in the closing report
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr      <= a;
    i_wr_data   <= d;
    i_wr_strobe <= 1'b1;
    @(posedge i_clock);
    i_wr_strobe <= 1'b0;
  endtask : wr

  // Read data are valid only in the cycle after the strobe, so sample there
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr      <= a;
    i_rd_strobe <= 1'b1;
    @(posedge i_clock);
    i_rd_strobe <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, o_rd_data);
  endtask : rdc

  task automatic frame(input logic [8:0] d, input logic nine, input logic stp, input int clks);
    u_tx.send(d, nine, stp, clks);
    repeat (4) @(posedge i_clock);
  endtask : frame

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int k = 0; k < 19; k++) begin
      if (rows[k].wr) wr(rows[k].a, rows[k].w);
      rdc(rows[k].a, rows[k].e);
    end
    // Divisor 0 at high rate gives a 16-clock bit
    wr(ADDR_BAUD_DIV, 8'h00);
    wr(ADDR_TX_STATUS, 8'h04);
    wr(ADDR_RX_STATUS, 8'h80);
    frame(9'h05A, 1'b0, 1'b1, 16);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_RX_STATUS, 8'h90);
    frame(9'h05A, 1'b0, 1'b1, 16);
    rdc(ADDR_IRQ_FLAGS, 8'h20);
    chk("rx_irq", 8'h01, {7'h00, o_rx_irq});
    chk("irq", 8'h01, {7'h00, o_irq});
    rdc(ADDR_EVT_STATUS, 8'h01);
    rdc(ADDR_RX_STATUS, 8'h90);
    rdc(ADDR_RX_DATA, 8'h5A);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_EVT_STATUS, 8'h01);
    rdc(ADDR_EVT_STATUS, 8'h00);
    chk("irq clr", 8'h00, {7'h00, o_irq});
    // Flags set even with both enables off
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_EVT_MASK, 8'h00);
    frame(9'h0A3, 1'b0, 1'b1, 16);
    rdc(ADDR_IRQ_FLAGS, 8'h20);
    chk("rx_irq off", 8'h00, {7'h00, o_rx_irq});
    chk("irq off", 8'h00, {7'h00, o_irq});
    wr(ADDR_IRQ_EN, 8'h20);
    wr(ADDR_EVT_MASK, 8'h07);
    rdc(ADDR_EVT_STATUS, 8'h01);
    chk("rx_irq on", 8'h01, {7'h00, o_rx_irq});
    chk("irq on", 8'h01, {7'h00, o_irq});
    rdc(ADDR_RX_DATA, 8'hA3);
    // Three words with no read: third is lost and overrun locks the FIFO
    frame(9'h011, 1'b0, 1'b1, 16);
    frame(9'h022, 1'b0, 1'b1, 16);
    frame(9'h033, 1'b0, 1'b1, 16);
    rdc(ADDR_RX_STATUS, 8'h92);
    rdc(ADDR_RX_DATA, 8'h11);
    rdc(ADDR_RX_DATA, 8'h22);
    rdc(ADDR_RX_DATA, 8'h00);
    frame(9'h044, 1'b0, 1'b1, 16);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    rdc(ADDR_RX_STATUS, 8'h92);
    wr(ADDR_RX_STATUS, 8'h80);
    rdc(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_RX_STATUS, 8'h90);
    frame(9'h055, 1'b0, 1'b1, 16);
    rdc(ADDR_RX_DATA, 8'h55);
    wr(ADDR_EVT_STATUS, 8'h07);
    // Nine-bit frames, second one with a low stop bit
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_RX_STATUS, 8'hC0);
    wr(ADDR_RX_STATUS, 8'hD0);
    frame(9'h1C3, 1'b1, 1'b1, 16);
    frame(9'h0A6, 1'b1, 1'b0, 16);
    rdc(ADDR_RX_STATUS, 8'hD1);
    rdc(ADDR_RX_DATA, 8'hC3);
    rdc(ADDR_RX_STATUS, 8'hD4);
    rdc(ADDR_RX_DATA, 8'hA6);
    rdc(ADDR_EVT_STATUS, 8'h05);
    // Low rate: 64 clocks a bit with divisor 0
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_TX_STATUS, 8'h00);
    wr(ADDR_RX_STATUS, 8'h90);
    frame(9'h03C, 1'b0, 1'b1, 64);
    rdc(ADDR_RX_DATA, 8'h3C);
    // Sync mode selected: the receiver must ignore the line
    wr(ADDR_BAUD_DIV, 8'h01);
    wr(ADDR_TX_STATUS, 8'h14);
    frame(9'h0C9, 1'b0, 1'b1, 32);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    // Divisor 1 at high rate gives a 32-clock bit
    wr(ADDR_TX_STATUS, 8'h04);
    frame(9'h0C9, 1'b0, 1'b1, 32);
    frame(9'h036, 1'b0, 1'b1, 32);
    rdc(ADDR_RX_STATUS, 8'h90);
    rdc(ADDR_RX_DATA, 8'hC9);
    chk("rx_irq pre", 8'h01, {7'h00, o_rx_irq});
    chk("irq pre", 8'h01, {7'h00, o_irq});
    // Mid-run reset with a word stored and both interrupts up
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    #1 chk("irq rst", 8'h00, {7'h00, o_irq});
    chk("rx_irq rst", 8'h00, {7'h00, o_rx_irq});
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    rdc(ADDR_RX_DATA, 8'h00);
    rdc(ADDR_TX_STATUS, 8'h02);
    rdc(ADDR_EVT_STATUS, 8'h00);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
